/* rtl/cpd_top.sv */
// Top of the four-pair complementary PWM output stage with dead time
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module cpd_top #(
  parameter int unsigned NUM_PAIRS = cpd_pkg::NUM_PAIRS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic duty_cycle_one,
  input wire logic duty_cycle_two,
  input wire logic duty_cycle_three,
  input wire logic duty_cycle_four,
  input wire logic timebase_enable,
  output logic pair1_high_out,
  output logic pair1_low_out,
  output logic pair2_high_out,
  output logic pair2_low_out,
  output logic pair3_high_out,
  output logic pair3_low_out,
  output logic pair4_high_out,
  output logic pair4_low_out
);

  if (NUM_PAIRS != 4) begin : g_check
    $error("cpd_top serves exactly four pairs");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] pair_independent_select;
    logic [15:0] deadtime_value_config;
    logic [7:0] deadtime_assign_config;
    logic [15:0] rdata;
  } cpd_regs_t;

  cpd_regs_t rg_r;
  cpd_regs_t rg_nxt;

  logic [3:0] duty;
  logic [3:0] high_nxt;
  logic [3:0] low_nxt;
  logic [3:0] busy;
  logic [3:0] high_r;
  logic [3:0] low_r;
  logic cfg_write;

  assign duty = {duty_cycle_four, duty_cycle_three, duty_cycle_two, duty_cycle_one};

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Either dead-time register written: clears every prescaler
  assign cfg_write = reg_wr && (hit(reg_addr, cpd_pkg::DEADTIME_VALUE_CONFIG_OFS) ||
                                hit(reg_addr, cpd_pkg::DEADTIME_ASSIGN_CONFIG_OFS));

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Writes while timebase_enable is high are accepted; results are the user's problem
  always_comb begin
    rg_nxt = rg_r;
    rg_nxt.rdata = 16'h0000;
    if (reg_wr) begin
      if (hit(reg_addr, cpd_pkg::OUTPUT_PAIR_CONFIG_OFS)) begin
        rg_nxt.pair_independent_select = reg_wdata[cpd_pkg::PAIR_INDEP_LSB +: 4];
      end
      if (hit(reg_addr, cpd_pkg::DEADTIME_VALUE_CONFIG_OFS)) begin
        rg_nxt.deadtime_value_config = reg_wdata;
      end
      if (hit(reg_addr, cpd_pkg::DEADTIME_ASSIGN_CONFIG_OFS)) begin
        rg_nxt.deadtime_assign_config = reg_wdata[7:0];
      end
    end
    if (reg_rd) begin
      if (hit(reg_addr, cpd_pkg::OUTPUT_PAIR_CONFIG_OFS)) begin
        rg_nxt.rdata = {12'h000, rg_r.pair_independent_select};
      end else if (hit(reg_addr, cpd_pkg::DEADTIME_VALUE_CONFIG_OFS)) begin
        rg_nxt.rdata = rg_r.deadtime_value_config;
      end else if (hit(reg_addr, cpd_pkg::DEADTIME_ASSIGN_CONFIG_OFS)) begin
        rg_nxt.rdata = {8'h00, rg_r.deadtime_assign_config};
      end else if (hit(reg_addr, cpd_pkg::PAIR_STATUS_OFS)) begin
        rg_nxt.rdata = {7'h00, timebase_enable, busy, duty};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rg_r.pair_independent_select <= cpd_pkg::PAIR_INDEP_RESET;
      rg_r.deadtime_value_config <= cpd_pkg::DT_VALUE_RESET;
      rg_r.deadtime_assign_config <= cpd_pkg::DT_ASSIGN_RESET;
      rg_r.rdata <= 16'h0000;
      high_r <= 4'h0;
      low_r <= 4'h0;
    end else begin
      rg_r <= rg_nxt;
      high_r <= high_nxt;
      low_r <= low_nxt;
    end
  end

  // ----------------------------------------
  // Dead-time units, one per pair
  // ----------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_pair
    cpd_deadtime_unit u_dt (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .duty_in(duty[i]),
      .indep_mode(rg_r.pair_independent_select[i]),
      .cfg_write(cfg_write),
      .count_a(rg_r.deadtime_value_config[cpd_pkg::DT_A_COUNT_LSB +: 6]),
      .prescale_a(rg_r.deadtime_value_config[cpd_pkg::DT_A_PRESCALE_LSB +: 2]),
      .count_b(rg_r.deadtime_value_config[cpd_pkg::DT_B_COUNT_LSB +: 6]),
      .prescale_b(rg_r.deadtime_value_config[cpd_pkg::DT_B_PRESCALE_LSB +: 2]),
      .active_sel(rg_r.deadtime_assign_config[2*i + cpd_pkg::ACTIVE_SEL_LSB]),
      .inactive_sel(rg_r.deadtime_assign_config[2*i + cpd_pkg::INACTIVE_SEL_LSB]),
      .high_nxt(high_nxt[i]),
      .low_nxt(low_nxt[i]),
      .busy(busy[i])
    );
  end

  assign reg_rdata = rg_r.rdata;
  assign pair1_high_out = high_r[0];
  assign pair1_low_out = low_r[0];
  assign pair2_high_out = high_r[1];
  assign pair2_low_out = low_r[1];
  assign pair3_high_out = high_r[2];
  assign pair3_low_out = low_r[2];
  assign pair4_high_out = high_r[3];
  assign pair4_low_out = low_r[3];

endmodule : cpd_top

`default_nettype wire

/* rtl/cpd_pkg.sv */
// Package of constants for the complementary PWM dead-time block
package cpd_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned DT_WIDTH = 6;
  localparam int unsigned PS_WIDTH = 2;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 16;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OUTPUT_PAIR_CONFIG_OFS = 4'h0;
  localparam logic [3:0] DEADTIME_VALUE_CONFIG_OFS = 4'h1;
  localparam logic [3:0] DEADTIME_ASSIGN_CONFIG_OFS = 4'h2;
  localparam logic [3:0] PAIR_STATUS_OFS = 4'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  // output_pair_config: bits 3:0 independent select per pair
  localparam int unsigned PAIR_INDEP_LSB = 0;
  // deadtime_value_config
  localparam int unsigned DT_A_COUNT_LSB = 0;
  localparam int unsigned DT_A_PRESCALE_LSB = 6;
  localparam int unsigned DT_B_COUNT_LSB = 8;
  localparam int unsigned DT_B_PRESCALE_LSB = 14;
  // deadtime_assign_config: pair n active sel at bit 2n, inactive at 2n+1
  localparam int unsigned ACTIVE_SEL_LSB = 0;
  localparam int unsigned INACTIVE_SEL_LSB = 1;
  // pair_status: bits 3:0 duty level, bits 7:4 dead time running
  localparam int unsigned STAT_DUTY_LSB = 0;
  localparam int unsigned STAT_BUSY_LSB = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] PAIR_INDEP_RESET = 4'h0;
  localparam logic [15:0] DT_VALUE_RESET = 16'h0000;
  localparam logic [7:0] DT_ASSIGN_RESET = 8'h00;

  // ----------------------------------------
  // Prescaler codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CPD_PS_DIV1 = 2'h0,
    CPD_PS_DIV2 = 2'h1,
    CPD_PS_DIV4 = 2'h2,
    CPD_PS_DIV8 = 2'h3
  } cpd_prescale_t;

endpackage : cpd_pkg

/* rtl/cpd_deadtime_unit.sv */
// One dead-time unit: edge detector, prescaler and 6-bit down counter
`timescale 1ns/1ps
`default_nettype none

module cpd_deadtime_unit (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic duty_in,
  input wire logic indep_mode,
  input wire logic cfg_write,
  input wire logic [5:0] count_a,
  input wire logic [1:0] prescale_a,
  input wire logic [5:0] count_b,
  input wire logic [1:0] prescale_b,
  input wire logic active_sel,
  input wire logic inactive_sel,
  output logic high_nxt,
  output logic low_nxt,
  output logic busy
);

  typedef struct packed {
    logic duty_d;
    logic [5:0] count;
    logic [2:0] presc;
    logic [1:0] ps_sel;
    logic high;
    logic low;
  } cpd_unit_state_t;

  cpd_unit_state_t st_r;
  cpd_unit_state_t st_nxt;

  // Terminal prescaler count for a 2-bit code
  function automatic logic [2:0] ps_last(input logic [1:0] code);
    unique case (cpd_pkg::cpd_prescale_t'(code))
      cpd_pkg::CPD_PS_DIV1: ps_last = 3'h0;
      cpd_pkg::CPD_PS_DIV2: ps_last = 3'h1;
      cpd_pkg::CPD_PS_DIV4: ps_last = 3'h3;
      cpd_pkg::CPD_PS_DIV8: ps_last = 3'h7;
    endcase
  endfunction : ps_last

  always_comb begin
    logic rise;
    logic fall;
    logic use_b;
    logic [5:0] load;
    rise = duty_in & ~st_r.duty_d;
    fall = ~duty_in & st_r.duty_d;
    use_b = rise ? active_sel : inactive_sel;
    load = use_b ? count_b : count_a;
    st_nxt = st_r;
    st_nxt.duty_d = duty_in;
    if (indep_mode) begin
      // No dead time outside complementary operation
      st_nxt.count = 6'h00;
      st_nxt.presc = 3'h0;
      st_nxt.high = duty_in;
      st_nxt.low = 1'b0;
    end else if (rise || fall) begin
      st_nxt.ps_sel = use_b ? prescale_b : prescale_a;
      st_nxt.presc = 3'h0;
      st_nxt.count = load;
      if (load == 6'h00) begin
        st_nxt.high = duty_in;
        st_nxt.low = ~duty_in;
      end else begin
        st_nxt.high = 1'b0;
        st_nxt.low = 1'b0;
      end
    end else begin
      if (cfg_write) begin
        st_nxt.presc = 3'h0;
      end else if (st_r.count != 6'h00) begin
        if (st_r.presc == ps_last(st_r.ps_sel)) begin
          st_nxt.presc = 3'h0;
          st_nxt.count = st_r.count - 6'h01;
        end else begin
          st_nxt.presc = st_r.presc + 3'h1;
        end
      end
      if (st_nxt.count == 6'h00) begin
        st_nxt.high = st_r.duty_d;
        st_nxt.low = ~st_r.duty_d;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign high_nxt = st_nxt.high;
  assign low_nxt = st_nxt.low;
  assign busy = st_r.count != 6'h00;

endmodule : cpd_deadtime_unit

`default_nettype wire

/* sim/cpd_gate_model.sv */
// Gate driver model for the four output pairs
`timescale 1ns/1ps
`default_nettype none
module cpd_gate_model (
  input wire logic mclk,
  input wire logic [3:0] gate_high,
  input wire logic [3:0] gate_low,
  output logic [7:0] shoot_cnt
);
  initial shoot_cnt = 8'h00;
  // Both devices of one leg on shorts the supply
  always @(posedge mclk) if ((gate_high & gate_low) != 4'h0) shoot_cnt <= shoot_cnt + 8'h01;
endmodule : cpd_gate_model
`default_nettype wire

/* sim/cpd_assertions.sv */
// Assertion checker on the ports of the dead-time top
`timescale 1ns/1ps
`default_nettype none
module cpd_checker #(
  parameter int unsigned NUM_PAIRS = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic duty_cycle_one,
  input wire logic duty_cycle_two,
  input wire logic pair1_high_out,
  input wire logic pair1_low_out,
  input wire logic pair2_high_out,
  input wire logic pair2_low_out
);
  logic [15:0] dtv_r;
  logic [3:0] opc_r;
  // ----
  // Shadow of output_pair_config and deadtime_value_config writes
  // ----
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dtv_r <= 16'h0000;
      opc_r <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == 4'h1) dtv_r <= reg_wdata;
      if (reg_addr == 4'h0) opc_r <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----
  // Properties
  // ----
  compl_ok_a: assert property (!(pair1_high_out && pair1_low_out) && !(pair2_high_out && pair2_low_out))
    else $error("both gates of a pair on");
  rise_cause_a: assert property ($rose(pair1_high_out) |-> $past(duty_cycle_one))
    else $error("high side on without duty");
  low_cause_a: assert property ($rose(pair1_low_out) |-> !$past(duty_cycle_one))
    else $error("low side on with duty");
  off_edge_a: assert property ($rose(duty_cycle_one) |=> !pair1_low_out)
    else $error("low side late to turn off");
  fall_off_a: assert property ($fell(duty_cycle_one) |=> !pair1_high_out)
    else $error("high side late to turn off");
  zero_delay_a: assert property ($rose(duty_cycle_one) && dtv_r == 16'h0000 && !opc_r[0] |=> pair1_high_out)
    else $error("zero dead time delayed");
  indep_follow_a: assert property (opc_r[1] |=> pair2_high_out == $past(duty_cycle_two) && !pair2_low_out)
    else $error("independent pair not following duty");
  rd_value_a: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata == $past(dtv_r))
    else $error("dead-time value readback wrong");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  rst_clear_a: assert property ($fell(sys_rst) |-> !pair1_high_out && !pair1_low_out && !pair2_low_out)
    else $error("outputs active after reset");
  cover property ($rose(pair1_high_out));
  cover property (opc_r[1] && $rose(duty_cycle_two));
  cover property (reg_rd && reg_addr == 4'h1);
endmodule : cpd_checker
`default_nettype wire

/* sim/complementary_pwm_deadtime_test.sv */
// Testbench for the complementary PWM dead-time block
`timescale 1ns/1ps
`default_nettype none
module complementary_pwm_deadtime_test;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] duty = 4'h0;
  logic tb_en = 1'b0;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [7:0] shoot_cnt;
  int mismatches = 0;
  int n_compared = 0;
  int k;
  always #12.5 mclk = ~mclk;
  cpd_top dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .duty_cycle_one(duty[0]), .duty_cycle_two(duty[1]), .duty_cycle_three(duty[2]),
    .duty_cycle_four(duty[3]), .timebase_enable(tb_en),
    .pair1_high_out(hi[0]), .pair1_low_out(lo[0]), .pair2_high_out(hi[1]), .pair2_low_out(lo[1]),
    .pair3_high_out(hi[2]), .pair3_low_out(lo[2]), .pair4_high_out(hi[3]), .pair4_low_out(lo[3])
  );
  cpd_gate_model gate_u (.mclk(mclk), .gate_high(hi), .gate_low(lo), .shoot_cnt(shoot_cnt));
  // ----
  // Tasks
  // ----
  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("read data", e, reg_rdata);
  endtask : rd
  // Toggle one duty line and time the turn-on of the newly active side
  task automatic meas(input int p, input logic v, input int exp);
    int n = 0;
    @(posedge mclk);
    duty[p] <= v;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (n == 1) chk("off side", 16'h0000, 16'(v ? lo[p] : hi[p]));
    end while ((v ? hi[p] : lo[p]) !== 1'b1 && n < 600);
    chk("dead time", 16'(exp + 1), 16'(n));
  endtask : meas
  // ----
  // Sequence
  // ----
  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 5; a++) rd(4'(a == 4 ? 7 : a), 16'h0000);
    chk("low sides", 16'h000f, 16'(lo));
    meas(0, 1'b1, 0);
    meas(0, 1'b0, 0);
    // Config only changes with the time base stopped
    wr(4'h2, 16'h0021);
    for (int c = 0; c < 4; c++) begin
      wr(4'h1, {2'(c), 6'h05, 2'(c), 6'h03});
      rd(4'h1, {2'(c), 6'h05, 2'(c), 6'h03});
      meas(0, 1'b1, 5 << c);
      chk("pair map", 16'h0001, 16'(hi));
      meas(0, 1'b0, 3 << c);
      meas(2, 1'b1, 3 << c);
      meas(2, 1'b0, 5 << c);
    end
    // Write lands one cycle into the interval and restarts the prescaler
    @(posedge mclk);
    duty[0] <= 1'b1;
    wr(4'h2, 16'h0021);
    rd(4'h3, 16'h0011);
    k = 3;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (hi[0] !== 1'b1 && k < 600);
    chk("prescaler clear", 16'h0029, 16'(k));
    meas(0, 1'b0, 3 << 3);
    wr(4'h0, 16'h0002);
    meas(1, 1'b1, 0);
    @(posedge mclk);
    duty[1] <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("independent pair", 16'h0000, 16'({hi[1], lo[1]}));
    @(posedge mclk);
    tb_en <= 1'b1;
    rd(4'h3, 16'h0100);
    chk("shoot through", 16'h0000, 16'(shoot_cnt));
    complete_run();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run();
  end
endmodule : complementary_pwm_deadtime_test
bind cpd_top cpd_checker #(.NUM_PAIRS(NUM_PAIRS)) chk_u (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .duty_cycle_one, .duty_cycle_two, .pair1_high_out, .pair1_low_out, .pair2_high_out,
  .pair2_low_out);
`default_nettype wire
